// File: design/cif_flag_cells.sv
`timescale 1ns/1ps
`default_nettype none
`include "cif_defs.svh"
module cif_flag_cells
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // flag traffic
  cif_flag_if.cells flags
);
  logic [7:0] pend_q;
  logic [7:0] pend_d;

  // sticky flags; a set in the clear cycle wins so no event is lost
  genvar i;
  generate
    for (i = 0; i < `CIF_NUM_SRC; i++)
    begin : g_cell
      always_comb
      begin
        pend_d[i] = flags.event_set[i] | (pend_q[i] & ~flags.host_clear[i]);
      end
    end
  endgenerate

  // register only
  always_ff @(posedge core_clk)
  begin
    if (srst)
      pend_q <= `CIF_RESET_BYTE;
    else
      pend_q <= pend_d;
  end

  assign flags.pending = pend_q;
endmodule : cif_flag_cells
`default_nettype wire

// File: design/cif_irq_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cif_defs.svh"
module cif_irq_regs
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register access from the serial host port decoder
  input wire cif_pkg::cif_addr_t reg_addr,
  input wire logic reg_wr,
  input wire cif_pkg::cif_byte_t reg_wdata,
  input wire logic reg_rd,
  output var cif_pkg::cif_byte_t reg_rdata,
  // source events, one-cycle pulses from controller logic
  input wire logic msg_error_evt,
  input wire logic wakeup_evt,
  input wire logic rx_buf0_loaded,
  input wire logic rx_buf1_loaded,
  input wire logic tx_buf0_empty_evt,
  input wire logic tx_buf1_empty_evt,
  input wire logic tx_buf2_empty_evt,
  // error flag register contents, same clock
  input wire cif_pkg::cif_byte_t error_flags,
  // interrupt output, active low like the pin
  output var logic irq_n
);
  import cif_pkg::*;

  cif_flag_if flags ();

  cif_flag_cells u_cells
  (
    .core_clk(core_clk),
    .srst(srst),
    .flags(flags)
  );

  cif_byte_t interrupt_enable_q;
  cif_byte_t interrupt_enable_d;
  cif_byte_t err_prev_q;
  cif_byte_t err_prev_d;
  cif_byte_t rdata_q;
  cif_byte_t rdata_d;
  logic irq_n_q;
  logic irq_n_d;
  logic err_seen_q;
  logic err_seen_d;
  logic [7:0] raw_evt;

  // ------------------------------------------------------------
  // event gathering
  // ------------------------------------------------------------
  // error change compares against last cycle; first cycle after reset
  // only captures, so a non-zero power-up value raises no false event
  always_comb
  begin
    raw_evt = `CIF_RESET_BYTE;
    raw_evt[`CIF_BIT_MSG_ERR] = msg_error_evt;
    raw_evt[`CIF_BIT_WAKEUP] = wakeup_evt;
    raw_evt[`CIF_BIT_ERR_CHG] = err_seen_q & (error_flags != err_prev_q);
    raw_evt[`CIF_BIT_TX2] = tx_buf2_empty_evt;
    raw_evt[`CIF_BIT_TX1] = tx_buf1_empty_evt;
    raw_evt[`CIF_BIT_TX0] = tx_buf0_empty_evt;
    raw_evt[`CIF_BIT_RX1] = rx_buf1_loaded;
    raw_evt[`CIF_BIT_RX0] = rx_buf0_loaded;
    err_prev_d = error_flags;
    err_seen_d = 1'b1;
  end

  // flags latch regardless of enable; the enable gates the output only
  // so software can still poll disabled sources
  assign flags.event_set = raw_evt;
  assign flags.host_clear = (reg_wr && reg_addr == `CIF_ADDR_PENDING) ?
                            ~reg_wdata : `CIF_RESET_BYTE;

  // ------------------------------------------------------------
  // register writes, reads and interrupt output
  // ------------------------------------------------------------
  always_comb
  begin
    interrupt_enable_d = interrupt_enable_q;
    if (reg_wr && reg_addr == `CIF_ADDR_ENABLE)
      interrupt_enable_d = reg_wdata;
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `CIF_ADDR_ENABLE: rdata_d = interrupt_enable_q;
        `CIF_ADDR_PENDING: rdata_d = flags.pending;
        `CIF_ADDR_ERRFLAGS: rdata_d = error_flags;
        default: rdata_d = `CIF_RESET_BYTE; // unmapped here reads zero
      endcase
    end
    irq_n_d = ~|(flags.pending & interrupt_enable_q);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      interrupt_enable_q <= `CIF_RESET_BYTE;
      err_prev_q <= `CIF_RESET_BYTE;
      err_seen_q <= 1'b0;
      rdata_q <= `CIF_RESET_BYTE;
      irq_n_q <= 1'b1;
    end
    else
    begin
      interrupt_enable_q <= interrupt_enable_d;
      err_prev_q <= err_prev_d;
      err_seen_q <= err_seen_d;
      rdata_q <= rdata_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_n = irq_n_q;
endmodule : cif_irq_regs
`default_nettype wire

// File: shared/cif_defs.svh
`ifndef CIF_DEFS_SVH
`define CIF_DEFS_SVH
`define CIF_ADDR_ENABLE 8'h2b
`define CIF_ADDR_PENDING 8'h2c
`define CIF_ADDR_ERRFLAGS 8'h2d
`define CIF_RESET_BYTE 8'h00
`define CIF_BIT_MSG_ERR 7
`define CIF_BIT_WAKEUP 6
`define CIF_BIT_ERR_CHG 5
`define CIF_BIT_TX2 4
`define CIF_BIT_TX1 3
`define CIF_BIT_TX0 2
`define CIF_BIT_RX1 1
`define CIF_BIT_RX0 0
`define CIF_NUM_SRC 8
`endif

// File: shared/cif_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries per-source flag state between the register block and the flag cells
interface cif_flag_if;
  logic [7:0] event_set;
  logic [7:0] host_clear;
  logic [7:0] pending;
  modport regs (output event_set, output host_clear, input pending);
  modport cells (input event_set, input host_clear, output pending);
endinterface : cif_flag_if
`default_nettype wire

// File: shared/cif_pkg.sv
package cif_pkg;
  typedef logic [7:0] cif_byte_t;
  typedef logic [7:0] cif_addr_t;
endpackage : cif_pkg

// File: tb/cif_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cif_host_model import cif_pkg::*; (
  // host side of the register port
  input wire logic core_clk,
  output var logic reg_wr, reg_rd,
  output var cif_addr_t reg_addr,
  output var cif_byte_t reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
  // held to the taking edge, then one idle cycle so strobes never retoggle in a step
  task automatic acc(logic w, cif_addr_t a, cif_byte_t d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge core_clk) #1;
    {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d}; // stale data inverted
    @(posedge core_clk) #1;
  endtask : acc
endmodule : cif_host_model
`default_nettype wire

// File: tb/cif_irq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cif_irq_asserts import cif_pkg::*; (
  // watched ports
  input wire logic core_clk, srst, reg_wr, reg_rd, rx_buf0_loaded, irq_n,
  input wire cif_addr_t reg_addr,
  input wire cif_byte_t reg_wdata, reg_rdata, error_flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // pending reads, enable writes with a quiet cycle after
  sequence r2c; reg_rd && !reg_wr && reg_addr==8'h2c; endsequence
  sequence w2b; reg_wr && reg_addr==8'h2b ##1 !reg_wr; endsequence
  property p_en; w2b ##1 reg_rd && reg_addr==8'h2b |=> reg_rdata==$past(reg_wdata,3); endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_blk; reg_wr && reg_addr==8'h2b && !reg_wdata |-> ##2 irq_n; endproperty
  a_blk: assert property (p_blk) else $error("mask");
  property p_set; rx_buf0_loaded ##1 r2c |=> reg_rdata[0]; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_keep; r2c ##1 !reg_wr ##1 r2c |=> !(~reg_rdata&$past(reg_rdata,2)); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_chg; !$stable(error_flags) && !$past(srst) ##1 r2c |=> reg_rdata[5]; endproperty
  a_chg: assert property (p_chg) else $error("change");
  property p_efl; reg_rd && reg_addr==8'h2d |=> reg_rdata==$past(error_flags); endproperty
  a_efl: assert property (p_efl) else $error("eflags");
  property p_irq; w2b ##1 r2c |=> irq_n==!(reg_rdata&$past(reg_wdata,3)); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_hold; !irq_n && !$past(reg_wr) |=> !irq_n; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  // main scenarios
  cover property (!irq_n);
  cover property (r2c ##2 r2c);
  cover property (reg_wr && reg_addr==8'h2c);
endmodule : cif_irq_asserts
bind cif_irq_regs cif_irq_asserts chk_u (.*);
`default_nettype wire

// File: tb/test_can_interrupt_enable_flags.sv
`timescale 1ns/1ps
`default_nettype none
module test_can_interrupt_enable_flags;
  import cif_pkg::*;
  logic core_clk = 0, srst = 1, rd_q = 0, reg_wr, reg_rd, irq_n;
  logic [7:0] ev = 0;
  cif_addr_t reg_addr;
  cif_byte_t reg_wdata, reg_rdata, r, error_flags = 0;
  cif_byte_t exp_q[$];
  int miscompares = 0, checked = 0;
  always #5 core_clk = ~core_clk;
  cif_host_model host_u (.*);
  cif_irq_regs dut_u (.*, .msg_error_evt(ev[7]), .wakeup_evt(ev[6]), .tx_buf2_empty_evt(ev[4]),
    .tx_buf1_empty_evt(ev[3]), .tx_buf0_empty_evt(ev[2]), .rx_buf1_loaded(ev[1]),
    .rx_buf0_loaded(ev[0]));
  task automatic cmp(cif_byte_t e);
    checked++;
    if (reg_rdata !== e) $display("MISMATCH reg_rdata exp %h got %h", e, reg_rdata);
    miscompares += int'(reg_rdata !== e);
  endtask : cmp
  task automatic cmp_irq(logic e);
    checked++;
    if (irq_n !== e) $display("MISMATCH irq_n exp %b got %b", e, irq_n);
    miscompares += int'(irq_n !== e);
  endtask : cmp_irq
  task automatic rd(cif_addr_t a, cif_byte_t e);
    exp_q.push_back(e);
    host_u.acc(0, a, 0);
  endtask : rd
  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // read data lands one edge after it is taken
  always @(posedge core_clk)
  begin
    rd_q <= reg_rd;
    if (rd_q === 1'b1) cmp(exp_q.pop_front());
  end
  initial
  begin
    void'($urandom(32'h1d50));
    repeat (10) @(posedge core_clk);
    #1 srst = 0;
    rd(8'h2b, 0);
    rd(8'h2c, 0);
    r = 8'($urandom);
    host_u.acc(1, 8'h2b, r);
    rd(8'h2b, r);
    host_u.acc(1, 8'h2b, 0);
    ev = 8'hdf;
    @(posedge core_clk) #1 ev = 0;
    rd(8'h2c, 8'hdf);
    cmp_irq(1'b1);
    rd(8'h2c, 8'hdf);
    host_u.acc(1, 8'h2b, 8'hff);
    rd(8'h2c, 8'hdf);
    cmp_irq(1'b0);
    host_u.acc(1, 8'h2c, 8'h0f);
    rd(8'h2c, 8'h0f);
    host_u.acc(1, 8'h2c, 0);
    cmp_irq(1'b1);
    error_flags = 8'($urandom) | 8'h01;
    @(posedge core_clk) #1;
    rd(8'h2c, 8'h20);
    cmp_irq(1'b0);
    host_u.acc(1, 8'h2d, 0);
    rd(8'h2d, error_flags);
    wrap_up();
  end
endmodule : test_can_interrupt_enable_flags
`default_nettype wire
